// file: core/ut_pkg.sv
package ut_pkg;
  localparam logic [7:0] A_STAT = 8'h00;
  localparam logic [7:0] A_CTRL = 8'h04;
  localparam logic [7:0] A_BAUD = 8'h08;
  localparam logic [7:0] A_TXD  = 8'h0c;
  localparam logic [7:0] A_RXD  = 8'h10;
  localparam int C_EN   = 0;
  localparam int C_TXE  = 1;
  localparam int C_RXE  = 2;
  localparam int C_BRK  = 3;
  localparam int C_NINE = 4;
  localparam int C_PEN  = 5;
  localparam int C_ODD  = 6;
  localparam int C_TWO  = 7;
  localparam int C_TX9  = 8;
  localparam int C_RIE  = 9;
  localparam int C_TIE  = 10;
  localparam logic [10:0] CTRL_RST = 11'h000;
  localparam logic [7:0]  BAUD_RST = 8'h00;
  localparam logic [3:0]  PH_LAST  = 4'hf;
  localparam logic [3:0]  PH_MID   = 4'h9;
  localparam logic [3:0]  BRK_LAST = 4'hc;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP, TX_BRK} ut_tx_e;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP, RX_WAIT} ut_rx_e;

  function automatic logic [3:0] nbits(input logic nine);
    return nine ? 4'h9 : 4'h8;
  endfunction

  function automatic logic par(input logic [8:0] d, input logic nine, input logic odd);
    logic [8:0] m;
    m = nine ? 9'h0ff : 9'h07f;
    return (^(d & m)) ^ odd;
  endfunction
endpackage

// file: core/ut_rx_vote.sv
`timescale 1ns/1ps
`default_nettype none
module ut_rx_vote (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic [7:0] div,
  input  wire logic       rx_i,
  output logic            tick16,
  output logic            vote,
  output logic            noisy
);
  logic [7:0] cnt_ff;
  logic       tick_ff;
  logic [2:0] hist_ff;
  wire        wrap = (cnt_ff == div);

  // 16x oversample tick and three-sample history
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_ff  <= 8'h00;
      tick_ff <= 1'b0;
      hist_ff <= 3'h7;
    end
    else
    begin
      cnt_ff  <= wrap ? 8'h00 : cnt_ff + 8'h01;
      tick_ff <= wrap;
      if (tick_ff)
        hist_ff <= {hist_ff[1:0], rx_i};
    end
  end

  assign tick16 = tick_ff;
  // majority of three samples, disagreement means noise
  assign vote   = (hist_ff[0] & hist_ff[1]) | (hist_ff[0] & hist_ff[2]) |
                  (hist_ff[1] & hist_ff[2]); // [RULE_09]
  assign noisy  = ~((&hist_ff) | ~(|hist_ff));
endmodule
`default_nettype wire

// file: core/ut_uart.sv
// Functional notes
// [RULE_01] busy-time write waits in holding register
// [RULE_02] idle-time write loads shifter, flag stays set
// [RULE_03] tx idle set when any frame ends
// [RULE_04] status access then data write clears flags
// [RULE_05] break: start, 13n zeros, stop bits
// [RULE_06] break frames raise no tx interrupt
// [RULE_07] breaks repeat while set, then two_stop_select
// [RULE_08] nine-bit mode keeps msb in ninth bit
// [RULE_09] 16x recovery, majority of three samples
// [RULE_10] lsb first shift, enable starts search
// [RULE_11] after stop sample word goes to fifo
// [RULE_12] two-word fifo plus shift register
// [RULE_13] overrun flags, keeps fifo, drops word
// [RULE_14] avail while fifo nonempty, irq per push
// [RULE_15] status access then data read pops
// [RULE_16] same sequence clears overrun
// [RULE_17] break received as zero word, framing
// [RULE_18] after bad stop wait for high line
// [RULE_19] rx idle low from start to stop
// [RULE_20] noise stored with word, no own irq
// [RULE_21] low stop bit sets framing error
// [RULE_22] parity flag per word when enabled
// [RULE_23] reset format is 8N1, lsb first
// [RULE_24] holding empty shows room for word
// [RULE_25] disable flushes and resets flags
// [RULE_26] sample mid-bit timed from start edge
//
// Chosen here: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module ut_uart (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  input  wire logic        rx_i,
  output logic             tx_o,
  output logic             tx_oe,
  output logic             rx_irq,
  output logic             tx_irq
);
  logic [10:0] ctl_ff, nxt_ctl;
  logic [7:0]  baud_ff;
  logic        ack_ff, seen_ff, rirq_ff, tirq_ff;
  logic [31:0] dat_ff;
  ut_pkg::ut_tx_e tst_ff, nxt_tst;
  logic [3:0]  tph_ff, nxt_tph, tcnt_ff, nxt_tcnt;
  logic [8:0]  tsh_ff, nxt_tsh, hold_ff;
  logic        tbrk_ff, nxt_tbrk, hempty_ff, tx_idle_flag_ff;
  ut_pkg::ut_rx_e rst_ff, nxt_rst;
  logic [3:0]  rph_ff, nxt_rph, rcnt_ff, nxt_rcnt;
  logic [8:0]  rsh_ff, nxt_rsh;
  logic        rnz_ff, nxt_rnz, rfe_ff, nxt_rfe, rx_idle_flag_ff, ovr_ff;
  logic [11:0] mem_ff [2];
  logic        wp_ff, rp_ff;
  logic [1:0]  cnt_ff;
  logic        tick, vote, noisy, rdone;

  // bus decode, one wait state
  wire acc  = cyc_i & stb_i & ~ack_ff;
  wire wr   = acc & we_i;
  wire rd   = acc & ~we_i;
  wire en   = ctl_ff[ut_pkg::C_EN];
  wire nine = ctl_ff[ut_pkg::C_NINE];
  wire pen  = ctl_ff[ut_pkg::C_PEN];
  wire odd  = ctl_ff[ut_pkg::C_ODD];
  wire two  = ctl_ff[ut_pkg::C_TWO];
  wire brk  = ctl_ff[ut_pkg::C_BRK];
  wire ten  = en & ctl_ff[ut_pkg::C_TXE];
  wire ren  = en & ctl_ff[ut_pkg::C_RXE];
  wire [3:0] nb    = ut_pkg::nbits(nine);
  wire [3:0] two_stop_select = two ? 4'h1 : 4'h0;
  wire txw  = wr & (adr_i == ut_pkg::A_TXD) & sel_i[0] & seen_ff & hempty_ff; // [RULE_04]
  wire rdd  = rd & (adr_i == ut_pkg::A_RXD) & seen_ff; // [RULE_15]
  wire pop  = rdd & (cnt_ff != 2'h0);
  wire t_idle   = ten & (tst_ff == ut_pkg::TX_IDLE) & ~brk;
  wire direct   = t_idle & hempty_ff & txw; // [RULE_02]
  wire ld_hold  = t_idle & ~hempty_ff; // [RULE_01]
  wire tbit     = tick & (tph_ff == ut_pkg::PH_LAST);
  wire tdone    = tbit & (tst_ff == ut_pkg::TX_STOP) & (tcnt_ff == two_stop_select);
  wire push     = rdone & (cnt_ff != 2'h2); // [RULE_11]
  wire ovf      = rdone & (cnt_ff == 2'h2); // [RULE_13]
  wire [11:0] head = mem_ff[rp_ff];
  wire [3:0]  hflg = (cnt_ff != 2'h0) ? head[11:8] : 4'h0; // [RULE_25]
  wire [8:0]  stat = {hflg[0], hflg[2], hflg[1], hflg[3], ovr_ff,
                      (cnt_ff != 2'h0), rx_idle_flag_ff, hempty_ff, tx_idle_flag_ff}; // [RULE_14]
  wire [31:0] rdat = (adr_i == ut_pkg::A_STAT) ? {23'h00_0000, stat} :
                     (adr_i == ut_pkg::A_CTRL) ? {21'h00_0000, ctl_ff} :
                     (adr_i == ut_pkg::A_BAUD) ? {24'h00_0000, baud_ff} :
                     (adr_i == ut_pkg::A_RXD)  ? {23'h00_0000, head[8:0]} : 32'h0000_0000;

  function automatic logic [8:0] tx_word(input logic [8:0] w, input logic n9,
                                         input logic p, input logic o);
    logic [8:0] r;
    r = n9 ? w : {1'b0, w[7:0]};
    if (p && n9)
      r[8] = ut_pkg::par(r, n9, o); // [RULE_22]
    else if (p)
      r[7] = ut_pkg::par(r, n9, o);
    return r;
  endfunction

  wire [8:0] tword = tx_word({ctl_ff[ut_pkg::C_TX9], dat_i[7:0]}, nine, pen, odd);

  ut_rx_vote u_vote (
    .clk    (clk),
    .arst_n (arst_n),
    .div    (baud_ff),
    .rx_i   (rx_i),
    .tick16 (tick),
    .vote   (vote),
    .noisy  (noisy)
  );

  always_comb
  begin
    nxt_ctl = ctl_ff;
    if (wr && adr_i == ut_pkg::A_CTRL && sel_i[0])
      nxt_ctl[7:0] = dat_i[7:0];
    if (wr && adr_i == ut_pkg::A_CTRL && sel_i[1])
      nxt_ctl[10:8] = dat_i[10:8];
    if (!nxt_ctl[ut_pkg::C_EN])
    begin
      nxt_ctl[ut_pkg::C_TXE] = 1'b0; // [RULE_25]
      nxt_ctl[ut_pkg::C_RXE] = 1'b0;
      nxt_ctl[ut_pkg::C_BRK] = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctl_ff  <= ut_pkg::CTRL_RST; // [RULE_23]
      baud_ff <= ut_pkg::BAUD_RST;
      ack_ff  <= 1'b0;
      dat_ff  <= 32'h0000_0000;
      seen_ff <= 1'b0;
    end
    else
    begin
      ctl_ff <= nxt_ctl;
      if (wr && adr_i == ut_pkg::A_BAUD && sel_i[0])
        baud_ff <= dat_i[7:0];
      ack_ff <= acc;
      if (rd)
        dat_ff <= rdat;
      if (rd && adr_i == ut_pkg::A_STAT)
        seen_ff <= 1'b1;
      else if (txw || rdd)
        seen_ff <= 1'b0;
    end
  end

  // transmitter
  always_comb
  begin
    nxt_tst  = tst_ff;
    nxt_tph  = (tick && tst_ff != ut_pkg::TX_IDLE) ? tph_ff + 4'h1 : tph_ff;
    nxt_tcnt = tcnt_ff;
    nxt_tsh  = tsh_ff;
    nxt_tbrk = tbrk_ff;
    case (tst_ff)
      ut_pkg::TX_IDLE:
      begin
        nxt_tph  = 4'h0;
        nxt_tcnt = 4'h0;
        if (ten && (brk || ld_hold || direct))
        begin
          nxt_tst  = ut_pkg::TX_START;
          nxt_tbrk = brk; // [RULE_05]
          nxt_tsh  = direct ? tword : hold_ff;
        end
      end
      ut_pkg::TX_START:
        if (tbit)
          nxt_tst = tbrk_ff ? ut_pkg::TX_BRK : ut_pkg::TX_DATA;
      ut_pkg::TX_DATA:
        if (tbit)
        begin
          nxt_tsh  = {1'b1, tsh_ff[8:1]}; // [RULE_23]
          nxt_tcnt = tcnt_ff + 4'h1;
          if (tcnt_ff == nb - 4'h1)
          begin
            nxt_tst  = ut_pkg::TX_STOP;
            nxt_tcnt = 4'h0;
          end
        end
      ut_pkg::TX_BRK:
        if (tbit)
        begin
          nxt_tcnt = tcnt_ff + 4'h1;
          if (tcnt_ff == ut_pkg::BRK_LAST)
          begin
            nxt_tcnt = 4'h0;
            if (!brk)
              nxt_tst = ut_pkg::TX_STOP; // [RULE_07]
          end
        end
      ut_pkg::TX_STOP:
        if (tbit)
        begin
          nxt_tcnt = tcnt_ff + 4'h1;
          if (tdone)
            nxt_tst = ut_pkg::TX_IDLE;
        end
      default:
        nxt_tst = ut_pkg::TX_IDLE;
    endcase
    if (!ten)
      nxt_tst = ut_pkg::TX_IDLE;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tst_ff    <= ut_pkg::TX_IDLE;
      tph_ff    <= 4'h0;
      tcnt_ff   <= 4'h0;
      tsh_ff    <= 9'h1ff;
      tbrk_ff   <= 1'b0;
      hold_ff   <= 9'h000;
      hempty_ff <= 1'b1;
      tx_idle_flag_ff  <= 1'b1;
      tirq_ff   <= 1'b0;
    end
    else
    begin
      tst_ff  <= nxt_tst;
      tph_ff  <= nxt_tph;
      tcnt_ff <= nxt_tcnt;
      tsh_ff  <= nxt_tsh;
      tbrk_ff <= nxt_tbrk;
      if (txw && !direct)
        hold_ff <= tword;
      if (!en || ld_hold)
        hempty_ff <= 1'b1; // [RULE_24]
      else if (txw && !direct)
        hempty_ff <= 1'b0;
      if (!en || tdone)
        tx_idle_flag_ff <= 1'b1; // [RULE_03]
      else if (txw)
        tx_idle_flag_ff <= 1'b0;
      tirq_ff <= ctl_ff[ut_pkg::C_TIE] & (ld_hold | direct); // [RULE_06]
    end
  end

  assign tx_o  = (tst_ff == ut_pkg::TX_START || tst_ff == ut_pkg::TX_BRK) ? 1'b0 :
                 (tst_ff == ut_pkg::TX_DATA) ? tsh_ff[0] : 1'b1;
  assign tx_oe = ten;

  // receiver
  wire rmid = tick & (rph_ff == ut_pkg::PH_MID); // [RULE_26]
  wire parity_error_flag = pen & (ut_pkg::par(rsh_ff, nine, odd) != rsh_ff[nb - 4'h1]); // [RULE_22]
  assign rdone = rmid & (rst_ff == ut_pkg::RX_STOP) & (rcnt_ff == two_stop_select);

  always_comb
  begin
    nxt_rst  = rst_ff;
    nxt_rph  = tick ? rph_ff + 4'h1 : rph_ff;
    nxt_rcnt = rcnt_ff;
    nxt_rsh  = rsh_ff;
    nxt_rnz  = rmid ? (rnz_ff | noisy) : rnz_ff; // [RULE_20]
    nxt_rfe  = rfe_ff;
    case (rst_ff)
      ut_pkg::RX_IDLE:
      begin
        nxt_rph  = 4'h0;
        nxt_rcnt = 4'h0;
        nxt_rnz  = 1'b0;
        nxt_rfe  = 1'b0;
        if (ren && tick && !rx_i)
          nxt_rst = ut_pkg::RX_START; // [RULE_10]
      end
      ut_pkg::RX_START:
        if (rmid)
          nxt_rst = vote ? ut_pkg::RX_IDLE : ut_pkg::RX_DATA;
      ut_pkg::RX_DATA:
        if (rmid)
        begin
          nxt_rsh  = nine ? {vote, rsh_ff[8:1]} : {1'b0, vote, rsh_ff[7:1]}; // [RULE_10]
          nxt_rcnt = rcnt_ff + 4'h1;
          if (rcnt_ff == nb - 4'h1)
          begin
            nxt_rst  = ut_pkg::RX_STOP;
            nxt_rcnt = 4'h0;
          end
        end
      ut_pkg::RX_STOP:
        if (rmid)
        begin
          nxt_rfe  = rfe_ff | ~vote; // [RULE_21]
          nxt_rcnt = rcnt_ff + 4'h1;
          if (rdone)
            nxt_rst = nxt_rfe ? ut_pkg::RX_WAIT : ut_pkg::RX_IDLE; // [RULE_18]
        end
      ut_pkg::RX_WAIT:
        if (tick && vote)
          nxt_rst = ut_pkg::RX_IDLE; // [RULE_18]
      default:
        nxt_rst = ut_pkg::RX_IDLE;
    endcase
    if (!ren)
      nxt_rst = ut_pkg::RX_IDLE;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_ff   <= ut_pkg::RX_IDLE;
      rph_ff   <= 4'h0;
      rcnt_ff  <= 4'h0;
      rsh_ff   <= 9'h000;
      rnz_ff   <= 1'b0;
      rfe_ff   <= 1'b0;
      rx_idle_flag_ff <= 1'b1;
      ovr_ff   <= 1'b0;
      wp_ff    <= 1'b0;
      rp_ff    <= 1'b0;
      cnt_ff   <= 2'h0;
      rirq_ff  <= 1'b0;
      mem_ff   <= '{12'h000, 12'h000};
    end
    else
    begin
      rst_ff  <= nxt_rst;
      rph_ff  <= nxt_rph;
      rcnt_ff <= nxt_rcnt;
      rsh_ff  <= nxt_rsh;
      rnz_ff  <= nxt_rnz;
      rfe_ff  <= nxt_rfe;
      if (!en || rdone)
        rx_idle_flag_ff <= 1'b1; // [RULE_19]
      else if (nxt_rst == ut_pkg::RX_START && rst_ff == ut_pkg::RX_IDLE)
        rx_idle_flag_ff <= 1'b0;
      if (!en)
        ovr_ff <= 1'b0;
      else if (ovf)
        ovr_ff <= 1'b1; // [RULE_13]
      else if (rdd)
        ovr_ff <= 1'b0; // [RULE_16]
      if (push)
      begin
        mem_ff[wp_ff] <= {nxt_rnz, parity_error_flag, nxt_rfe, nine & rsh_ff[8], rsh_ff[7:0]}; // [RULE_17]
        wp_ff <= ~wp_ff;
      end
      if (pop)
        rp_ff <= ~rp_ff;
      cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop}; // [RULE_12]
      if (!en)
      begin
        wp_ff  <= 1'b0;
        rp_ff  <= 1'b0;
        cnt_ff <= 2'h0;
      end
      rirq_ff <= ctl_ff[ut_pkg::C_RIE] & (push | ovf); // [RULE_14]
    end
  end

  assign dat_o  = dat_ff;
  assign ack_o  = ack_ff;
  assign rx_irq = rirq_ff;
  assign tx_irq = tirq_ff;

  property p_tx_direct;
    @(posedge clk) disable iff (!arst_n) direct |=> tst_ff == ut_pkg::TX_START && hempty_ff;
  endproperty
  a_tx_direct: assert property (p_tx_direct) else $error("direct load failed"); // [RULE_02]

  property p_tx_hold;
    @(posedge clk) disable iff (!arst_n)
      (txw && !direct && en) |=> !hempty_ff && hold_ff == $past(tword);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("held word lost"); // [RULE_01]

  property p_tx_idle;
    @(posedge clk) disable iff (!arst_n) tdone |=> tx_idle_flag_ff && tst_ff == ut_pkg::TX_IDLE;
  endproperty
  a_tx_idle: assert property (p_tx_idle) else $error("tx idle not set"); // [RULE_03]

  property p_brk_low;
    @(posedge clk) disable iff (!arst_n) tst_ff == ut_pkg::TX_BRK |-> !tx_o && !tirq_ff;
  endproperty
  a_brk_low: assert property (p_brk_low) else $error("break not low"); // [RULE_05]

  property p_push;
    @(posedge clk) disable iff (!arst_n)
      (push && en && !pop) |=> cnt_ff == $past(cnt_ff) + 2'h1 && stat[3];
  endproperty
  a_push: assert property (p_push) else $error("push lost"); // [RULE_14]

  property p_ovr;
    @(posedge clk) disable iff (!arst_n) (ovf && en && !pop) |=> ovr_ff && cnt_ff == 2'h2;
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun wrong"); // [RULE_13]

  property p_rx_idle_flag;
    @(posedge clk) disable iff (!arst_n)
      (rst_ff == ut_pkg::RX_IDLE && nxt_rst == ut_pkg::RX_START && en) |=> !rx_idle_flag_ff;
  endproperty
  a_rx_idle_flag: assert property (p_rx_idle_flag) else $error("rx idle stuck"); // [RULE_19]

  property p_wait;
    @(posedge clk) disable iff (!arst_n)
      (rst_ff == ut_pkg::RX_WAIT && !vote && ren) |=> rst_ff == ut_pkg::RX_WAIT;
  endproperty
  a_wait: assert property (p_wait) else $error("low line taken as start"); // [RULE_18]

  property p_dis;
    @(posedge clk) disable iff (!arst_n)
      !en ##1 !en |-> tx_idle_flag_ff && hempty_ff && rx_idle_flag_ff && cnt_ff == 2'h0 && !ovr_ff;
  endproperty
  a_dis: assert property (p_dis) else $error("disable state wrong"); // [RULE_25]
endmodule
`default_nettype wire

// file: dv/ut_remote.sv
`timescale 1ns/1ps
`default_nettype none
module ut_remote (
  input  wire logic clk,
  input  wire logic tx_line,
  output logic      rx_line
);
  localparam int BT = 16;
  initial rx_line = 1'b1;
  // frame: start, nb data bits lsb first, stop level, then idle high
  task automatic send(input logic [8:0] d, input int nb, input logic stp);
    rx_line <= 1'b0;
    repeat (BT) @(posedge clk);
    for (int i = 0; i < nb; i++)
    begin
      rx_line <= d[i];
      repeat (BT) @(posedge clk);
    end
    rx_line <= stp;
    repeat (BT) @(posedge clk);
    rx_line <= 1'b1;
    repeat (BT) @(posedge clk);
  endtask
  // capture one 8-bit frame mid-bit; v[8] is the stop level
  task automatic grab(output logic [8:0] v);
    int n;
    n = 0;
    while (tx_line !== 1'b0 && n < 4000)
    begin
      @(posedge clk);
      n++;
    end
    repeat (BT / 2) @(posedge clk);
    for (int i = 0; i < 9; i++)
    begin
      repeat (BT) @(posedge clk);
      v[i] = tx_line;
    end
  endtask
endmodule
`default_nettype wire

// file: dv/ut_uart_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ut_uart_tb;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dat = 32'h0000_0000;
  logic [31:0] rdat;
  logic        ack;
  logic        rx_line;
  logic        tx_o;
  logic        tx_oe;
  logic        rx_irq;
  logic        tx_irq;
  int          errors = 0;
  int          n_compared = 0;
  int          rx_n = 0;
  int          tx_n = 0;
  int          c;
  logic [31:0] q;
  logic [8:0]  d1;
  logic [8:0]  d2;

  always #5 clk = ~clk;
  always @(posedge clk)
  begin
    if (rx_irq === 1'b1)
      rx_n <= rx_n + 1;
    if (tx_irq === 1'b1)
      tx_n <= tx_n + 1;
  end

  ut_uart dut_u (
    .clk    (clk),
    .arst_n (arst_n),
    .cyc_i  (cyc),
    .stb_i  (stb),
    .we_i   (we),
    .adr_i  (adr),
    .sel_i  (4'h3),
    .dat_i  (dat),
    .dat_o  (rdat),
    .ack_o  (ack),
    .rx_i   (rx_line),
    .tx_o   (tx_o),
    .tx_oe  (tx_oe),
    .rx_irq (rx_irq),
    .tx_irq (tx_irq)
  );
  ut_remote rem_u (
    .clk     (clk),
    .tx_line (tx_o),
    .rx_line (rx_line)
  );

  task automatic results();
    if (errors == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    @(posedge clk);
    while (ack !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 20)
    begin
      errors++;
      results();
    end
    @(posedge clk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    wb(1'b0, a, 32'h0000_0000);
    chk(e, q & m);
  endtask
  task automatic st(input logic [31:0] m, input logic [31:0] e);
    rdc(ut_pkg::A_STAT, m, e);
  endtask

  task automatic t_tx();
    wb(1'b1, ut_pkg::A_CTRL, 32'h0000_0407);
    chk(32'h0000_0001, {31'h0, tx_oe});
    fork
      begin
        st(32'h0000_0003, 32'h0000_0003);
        wb(1'b1, ut_pkg::A_TXD, 32'h0000_0055);
        st(32'h0000_0003, 32'h0000_0002);
        wb(1'b1, ut_pkg::A_TXD, 32'h0000_00a3);
        st(32'h0000_0003, 32'h0000_0000);
      end
      begin
        rem_u.grab(d1);
        rem_u.grab(d2);
      end
    join
    chk(32'h0000_0155, {23'h0, d1});
    chk(32'h0000_01a3, {23'h0, d2});
    repeat (16) @(posedge clk);
    st(32'h0000_0001, 32'h0000_0001);
    chk(32'h0000_0002, 32'(tx_n));
  endtask

  task automatic t_brk();
    fork
      begin
        wb(1'b1, ut_pkg::A_CTRL, 32'h0000_040f);
        repeat (20) @(posedge clk);
        wb(1'b1, ut_pkg::A_CTRL, 32'h0000_0407);
      end
      begin
        c = 0;
        while (tx_o !== 1'b0 && c < 100)
        begin
          @(posedge clk);
          c++;
        end
        c = 0;
        while (tx_o === 1'b0 && c < 1000)
        begin
          @(posedge clk);
          c++;
        end
      end
    join
    chk(32'h0000_00e0, 32'(c));
    repeat (8) @(posedge clk);
    chk(32'h0000_0001, {31'h0, tx_o});
    repeat (16) @(posedge clk);
    st(32'h0000_0001, 32'h0000_0001);
    chk(32'h0000_0002, 32'(tx_n));
  endtask

  task automatic t_rx();
    wb(1'b1, ut_pkg::A_CTRL, 32'h0000_0207);
    rem_u.send(9'h03c, 8, 1'b1);
    st(32'h0000_01fc, 32'h0000_000c);
    rdc(ut_pkg::A_RXD, 32'h0000_01ff, 32'h0000_003c);
    st(32'h0000_0008, 32'h0000_0000);
    rem_u.send(9'h011, 8, 1'b1);
    rem_u.send(9'h022, 8, 1'b1);
    rem_u.send(9'h033, 8, 1'b1);
    st(32'h0000_0018, 32'h0000_0018);
    rdc(ut_pkg::A_RXD, 32'h0000_00ff, 32'h0000_0011);
    st(32'h0000_0018, 32'h0000_0008);
    rdc(ut_pkg::A_RXD, 32'h0000_00ff, 32'h0000_0022);
    st(32'h0000_0008, 32'h0000_0000);
    chk(32'h0000_0004, 32'(rx_n));
  endtask

  task automatic t_err();
    rem_u.send(9'h05a, 8, 1'b0);
    st(32'h0000_0048, 32'h0000_0048);
    rdc(ut_pkg::A_RXD, 32'h0000_00ff, 32'h0000_005a);
    rem_u.send(9'h000, 20, 1'b0);
    st(32'h0000_004c, 32'h0000_004c);
    rdc(ut_pkg::A_RXD, 32'h0000_01ff, 32'h0000_0000);
    st(32'h0000_0008, 32'h0000_0000);
    wb(1'b1, ut_pkg::A_CTRL, 32'h0000_0227);
    rem_u.send(9'h081, 8, 1'b1);
    rem_u.send(9'h001, 8, 1'b1);
    st(32'h0000_0088, 32'h0000_0008);
    rdc(ut_pkg::A_RXD, 32'h0000_007f, 32'h0000_0001);
    st(32'h0000_0088, 32'h0000_0088);
    rdc(ut_pkg::A_RXD, 32'h0000_007f, 32'h0000_0001);
  endtask

  task automatic t_fmt();
    wb(1'b1, ut_pkg::A_CTRL, 32'h0000_0217);
    rem_u.send(9'h1a5, 9, 1'b1);
    st(32'h0000_0108, 32'h0000_0108);
    rdc(ut_pkg::A_RXD, 32'h0000_01ff, 32'h0000_01a5);
    rem_u.send(9'h077, 9, 1'b1);
    wb(1'b1, ut_pkg::A_CTRL, 32'h0000_0216);
    rdc(ut_pkg::A_CTRL, 32'h0000_07ff, 32'h0000_0210);
    chk(32'h0000_0000, {31'h0, tx_oe});
    st(32'h0000_01ff, 32'h0000_0007);
  endtask

  initial
  begin
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    st(32'h0000_01ff, 32'h0000_0007);
    rdc(ut_pkg::A_CTRL, 32'h0000_07ff, 32'h0000_0000);
    rdc(ut_pkg::A_BAUD, 32'h0000_00ff, 32'h0000_0000);
    rdc(8'h20, 32'hffff_ffff, 32'h0000_0000);
    t_tx();
    t_brk();
    t_rx();
    t_err();
    t_fmt();
    results();
  end
endmodule
`default_nettype wire
